// ---- vms_map.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef VMS_MAP_SVH
`define VMS_MAP_SVH
`define VMS_OFF_GLOBAL_CONFIG_REG 8'h00
`define VMS_OFF_CURRENT 8'h04
`define VMS_OFF_QC_UPPER 8'h08
`define VMS_OFF_HS 8'h0C
`define VMS_OFF_LA_LOWER 8'h10
`define VMS_OFF_STEP_IVAL 8'h14
`define VMS_OFF_STATUS 8'h18
`define VMS_GLOBAL_CONFIG_REG_SMALL_HYST 0
`define VMS_GLOBAL_CONFIG_REG_STEP_EXT 1
`define VMS_GLOBAL_CONFIG_REG_MRES_LSB 4
`define VMS_CUR_RUN_LSB 0
`define VMS_CUR_HOLD_LSB 8
`define VMS_ST_STST 0
`define VMS_ST_QC 1
`define VMS_ST_HS 2
`define VMS_ST_LA 3
`define VMS_RST_GLOBAL_CONFIG_REG 6'h00
`define VMS_RST_RUN 5'h10
`define VMS_RST_HOLD 5'h08
`define VMS_RST_THR 20'h00000
`define VMS_RST_IVAL 20'hFFFFF
`define VMS_MRES_MAX 4'h8
`define VMS_STST_CYCLES 1048576
`define VMS_RESP_OKAY 2'h0
`define VMS_RESP_SLVERR 2'h2
`endif

// ---- vms_pkg.sv ----
// Types shared by the velocity mode selector
package vms_pkg;
  typedef struct packed {
    logic [3:0] mres;
    logic step_ext;
    logic small_hyst;
  } vms_cfg_t;

  typedef struct packed {
    logic load_adapt;
    logic high_speed;
    logic quiet_chop;
  } vms_mode_t;

  typedef struct packed {
    logic [4:0] hold;
    logic [4:0] run;
  } vms_cur_t;
endpackage : vms_pkg

// ---- vms_velocity_mode_select.sv ----
// Step interval measurement and velocity based mode selection, one axis
`timescale 1ns/1ps
`include "vms_map.svh"

// Overview of operation
// - Velocity is held as the clock count between two consecutive steps.
// - The measured interval is scaled to 256 microsteps per full step.
// - Steps may come from the internal ramp or from an external step pin.
// - Three programmable intervals give the three velocity switch points.
// - The normalised interval is compared with each threshold to set modes.
// - Each comparison has hysteresis of 1/16 or 1/32 of the threshold.
// - Upward switching needs the velocity raised by the hysteresis share.
// - One global bit picks 1/32 when set and 1/16 when clear.
// - Current is the run level when moving and the hold level at standstill.
// - Each mode is only enabled within its threshold-bounded window.
// - Modes switch from the comparisons and standstill, with no software writes.
// - Standstill sets after 2^20 clocks with no step and resets to zero.
module vms_velocity_mode_select #(
  parameter int STST_CYCLES = `VMS_STST_CYCLES,
  parameter int IVAL_W = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic step_int,
  input wire logic step_ext_pin,
  output vms_pkg::vms_mode_t mode,
  output logic standstill,
  output logic [4:0] current_scale,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int CNT_W = IVAL_W + 1;
  localparam logic [CNT_W-1:0] STST_CNT = CNT_W'(STST_CYCLES);
  localparam logic [IVAL_W-1:0] IVAL_MAX = {IVAL_W{1'b1}};

  // Merge byte lanes of a write into the old word
  function automatic logic [31:0] apply_strb(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction : apply_strb

  // Fast means interval at or below threshold, with a hysteresis band
  function automatic logic hyst_fast(
    input logic prev,
    input logic [IVAL_W-1:0] ival,
    input logic [IVAL_W-1:0] thr,
    input logic use_small
  );
    logic [IVAL_W-1:0] delta;
    delta = use_small ? (thr >> 5) : (thr >> 4);
    if (prev) begin
      return ival <= thr;
    end
    return ival <= (thr - delta);
  endfunction : hyst_fast

  // Configuration and threshold registers
  vms_pkg::vms_cfg_t cfg_ff;
  vms_pkg::vms_cur_t cur_ff;
  logic [IVAL_W-1:0] qc_upper_ff;
  logic [IVAL_W-1:0] hs_ff;
  logic [IVAL_W-1:0] la_lower_ff;

  // Step path
  logic ext_meta_ff;
  logic ext_sync_ff;
  logic ext_prev_ff;
  logic int_prev_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [IVAL_W-1:0] step_interval_ff;
  logic stst_ff;

  // Mode state
  logic fast_qc_ff;
  logic fast_hs_ff;
  logic fast_la_ff;
  vms_pkg::vms_mode_t mode_ff;
  logic [4:0] current_ff;

  // Bus state
  logic aw_got_ff;
  logic w_got_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  // Step edge selection
  wire step_edge_int = step_int & ~int_prev_ff;
  wire step_edge_ext = ext_sync_ff & ~ext_prev_ff;
  wire step_edge = cfg_ff.step_ext ? step_edge_ext : step_edge_int;

  wire [3:0] mres_eff = (cfg_ff.mres > `VMS_MRES_MAX) ?
                        `VMS_MRES_MAX : cfg_ff.mres;
  // A coarse step spans 2^mres fine steps, so the count shrinks by that
  wire [CNT_W-1:0] cnt_norm = cnt_ff >> mres_eff;
  wire [IVAL_W-1:0] ival_sat = cnt_norm[CNT_W-1] ?
                               IVAL_MAX : cnt_norm[IVAL_W-1:0];
  wire cnt_done = cnt_ff >= STST_CNT;
  wire [CNT_W-1:0] nxt_cnt = step_edge ? CNT_W'(1) :
                             cnt_done ? cnt_ff : cnt_ff + CNT_W'(1);
  wire nxt_stst = step_edge ? 1'b0 : (cnt_done | stst_ff);

  // Velocity windows
  wire nxt_fast_qc = hyst_fast(fast_qc_ff, step_interval_ff,
                               qc_upper_ff, cfg_ff.small_hyst);
  wire nxt_fast_hs = hyst_fast(fast_hs_ff, step_interval_ff,
                               hs_ff, cfg_ff.small_hyst);
  wire nxt_fast_la = hyst_fast(fast_la_ff, step_interval_ff,
                               la_lower_ff, cfg_ff.small_hyst);
  vms_pkg::vms_mode_t nxt_mode;
  assign nxt_mode.quiet_chop = ~fast_qc_ff & ~fast_hs_ff;
  assign nxt_mode.high_speed = fast_hs_ff;
  // Load adaption is unreliable at standstill and at high speed
  assign nxt_mode.load_adapt = fast_la_ff & ~fast_hs_ff & ~stst_ff;
  wire [4:0] nxt_current = stst_ff ? cur_ff.hold : cur_ff.run;

  // Write decode
  wire wr_go = aw_got_ff & w_got_ff & ~bvalid_ff;
  wire wr_global_config_reg = awaddr_ff == `VMS_OFF_GLOBAL_CONFIG_REG;
  wire wr_cur = awaddr_ff == `VMS_OFF_CURRENT;
  wire wr_qc = awaddr_ff == `VMS_OFF_QC_UPPER;
  wire wr_hs = awaddr_ff == `VMS_OFF_HS;
  wire wr_la = awaddr_ff == `VMS_OFF_LA_LOWER;
  wire wr_hit = wr_global_config_reg | wr_cur | wr_qc | wr_hs | wr_la;

  wire [31:0] cfg_word = {24'h000000, cfg_ff.mres, 2'h0,
                          cfg_ff.step_ext, cfg_ff.small_hyst};
  wire [31:0] cur_word = {19'h00000, cur_ff.hold, 3'h0, cur_ff.run};
  wire [31:0] cfg_new = apply_strb(cfg_word, wdata_ff, wstrb_ff);
  wire [31:0] cur_new = apply_strb(cur_word, wdata_ff, wstrb_ff);
  wire [31:0] qc_new = apply_strb(32'(qc_upper_ff), wdata_ff, wstrb_ff);
  wire [31:0] hs_new = apply_strb(32'(hs_ff), wdata_ff, wstrb_ff);
  wire [31:0] la_new = apply_strb(32'(la_lower_ff), wdata_ff, wstrb_ff);

  // Read decode
  wire [31:0] status_word = {28'h0000000, mode_ff.load_adapt,
                             mode_ff.high_speed, mode_ff.quiet_chop,
                             stst_ff};
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  wire rd_hit = (ra == `VMS_OFF_GLOBAL_CONFIG_REG) | (ra == `VMS_OFF_CURRENT) |
                (ra == `VMS_OFF_QC_UPPER) | (ra == `VMS_OFF_HS) |
                (ra == `VMS_OFF_LA_LOWER) | (ra == `VMS_OFF_STEP_IVAL) |
                (ra == `VMS_OFF_STATUS);
  wire [31:0] rd_word =
    (ra == `VMS_OFF_GLOBAL_CONFIG_REG) ? cfg_word :
    (ra == `VMS_OFF_CURRENT) ? cur_word :
    (ra == `VMS_OFF_QC_UPPER) ? 32'(qc_upper_ff) :
    (ra == `VMS_OFF_HS) ? 32'(hs_ff) :
    (ra == `VMS_OFF_LA_LOWER) ? 32'(la_lower_ff) :
    (ra == `VMS_OFF_STEP_IVAL) ? 32'(step_interval_ff) :
    (ra == `VMS_OFF_STATUS) ? status_word : 32'h00000000;
  wire rd_go = s_axi_arvalid & ~rvalid_ff;

  assign s_axi_awready = ~aw_got_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_got_ff & ~bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign mode = mode_ff;
  assign standstill = stst_ff;
  assign current_scale = current_ff;

  // External step pin synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_meta_ff <= 1'b0;
      ext_sync_ff <= 1'b0;
      ext_prev_ff <= 1'b0;
      int_prev_ff <= 1'b0;
    end else begin
      ext_meta_ff <= step_ext_pin;
      ext_sync_ff <= ext_meta_ff;
      ext_prev_ff <= ext_sync_ff;
      int_prev_ff <= step_int;
    end
  end

  // Interval counter; saturates so standstill reads as slowest velocity
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= '0;
      stst_ff <= 1'b0;
      step_interval_ff <= `VMS_RST_IVAL;
    end else begin
      cnt_ff <= nxt_cnt;
      stst_ff <= nxt_stst;
      if (step_edge) begin
        step_interval_ff <= ival_sat;
      end else if (cnt_done) begin
        step_interval_ff <= IVAL_MAX;
      end
    end
  end

  // Mode flags follow the interval every cycle without software help
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fast_qc_ff <= 1'b0;
      fast_hs_ff <= 1'b0;
      fast_la_ff <= 1'b0;
      mode_ff <= '0;
      current_ff <= `VMS_RST_HOLD;
    end else begin
      fast_qc_ff <= nxt_fast_qc;
      fast_hs_ff <= nxt_fast_hs;
      fast_la_ff <= nxt_fast_la;
      mode_ff <= nxt_mode;
      current_ff <= nxt_current;
    end
  end

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_ff <= `VMS_RST_GLOBAL_CONFIG_REG;
      cur_ff <= {`VMS_RST_HOLD, `VMS_RST_RUN};
      qc_upper_ff <= `VMS_RST_THR;
      hs_ff <= `VMS_RST_THR;
      la_lower_ff <= `VMS_RST_THR;
    end else if (wr_go) begin
      if (wr_global_config_reg) begin
        cfg_ff.small_hyst <= cfg_new[`VMS_GLOBAL_CONFIG_REG_SMALL_HYST];
        cfg_ff.step_ext <= cfg_new[`VMS_GLOBAL_CONFIG_REG_STEP_EXT];
        cfg_ff.mres <= cfg_new[`VMS_GLOBAL_CONFIG_REG_MRES_LSB +: 4];
      end
      if (wr_cur) begin
        cur_ff.run <= cur_new[`VMS_CUR_RUN_LSB +: 5];
        cur_ff.hold <= cur_new[`VMS_CUR_HOLD_LSB +: 5];
      end
      if (wr_qc) begin
        qc_upper_ff <= qc_new[IVAL_W-1:0];
      end
      if (wr_hs) begin
        hs_ff <= hs_new[IVAL_W-1:0];
      end
      if (wr_la) begin
        la_lower_ff <= la_new[IVAL_W-1:0];
      end
    end
  end

  // Write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `VMS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? `VMS_RESP_OKAY : `VMS_RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `VMS_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= rd_hit ? `VMS_RESP_OKAY : `VMS_RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule : vms_velocity_mode_select

// ---- vms_mode_checker_assertions.sv ----
// Port-level checks for the velocity mode selector
`timescale 1ns/1ps
module vms_mode_checker #(
  parameter int STST_CYCLES = 1048576
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic step_int,
  input wire logic step_ext_pin,
  input wire vms_pkg::vms_mode_t mode,
  input wire logic standstill,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  int quiet_ff;
  int since_ff;
  logic int_q_ff;
  logic ext_q_ff;
  wire edge_seen = (step_int && !int_q_ff) || (step_ext_pin && !ext_q_ff);
  // Counters saturate so a long stop cannot wrap and fake a recent step
  always_ff @(posedge aclk) begin
    int_q_ff <= step_int;
    ext_q_ff <= step_ext_pin;
    if (!aresetn || edge_seen) quiet_ff <= 0;
    else if (quiet_ff < STST_CYCLES + 8) quiet_ff <= quiet_ff + 1;
    if (!aresetn || edge_seen || s_axi_bvalid || $changed(standstill))
      since_ff <= 0;
    else if (since_ff < 64) since_ff <= since_ff + 1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence rd_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  // Both halves are held one cycle before the response is raised
  wr_resp_a: assert property (wr_both |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  rd_resp_a: assert property (rd_take |=> s_axi_rvalid ##0 !s_axi_arready)
    else $error("read response missing");
  rd_hold_a: assert property (rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  mode_excl_a: assert property (
    mode.high_speed |-> !mode.quiet_chop && !mode.load_adapt)
    else $error("high speed overlaps another mode");
  stst_reset_a: assert property (disable iff (1'b0)
    !aresetn |=> !standstill && !s_axi_bvalid && !s_axi_rvalid)
    else $error("reset values wrong");
  stst_early_a: assert property (
    $rose(standstill) |-> quiet_ff >= STST_CYCLES - 4)
    else $error("standstill too early");
  stst_late_a: assert property (
    quiet_ff == STST_CYCLES + 8 |-> standstill)
    else $error("standstill too late");
  stst_clear_a: assert property (
    $fell(standstill) |-> quiet_ff < 8)
    else $error("standstill cleared without step");
  la_stst_a: assert property (standstill [*4] |-> !mode.load_adapt)
    else $error("load adapt on at standstill");
  mode_cause_a: assert property ($changed(mode) |-> since_ff < 12)
    else $error("mode changed without cause");
endmodule : vms_mode_checker

bind vms_velocity_mode_select vms_mode_checker #(.STST_CYCLES(STST_CYCLES))
  i_vms_mode_checker (.aclk, .aresetn, .step_int, .step_ext_pin, .mode,
  .standstill, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata);

// ---- vms_step_source.sv ----
// Step pulse source standing for the ramp or an external step driver
`timescale 1ns/1ps
module vms_step_source (
  input wire logic aclk,
  input wire logic [15:0] gap,
  input wire logic ext,
  output logic step_int,
  output logic step_ext_pin
);
  logic [15:0] cnt_ff = 16'h0000;
  logic pulse_ff = 1'b0;
  wire wrap = cnt_ff + 16'h0001 >= gap;
  // Gap zero stops stepping; the unchosen line stays low
  always_ff @(posedge aclk) begin
    cnt_ff <= (gap == 16'h0000 || wrap) ? 16'h0000 : cnt_ff + 16'h0001;
    pulse_ff <= gap != 16'h0000 && wrap;
  end
  assign step_int = pulse_ff && !ext;
  assign step_ext_pin = pulse_ff && ext;
endmodule : vms_step_source

// ---- vms_velocity_mode_select_test.sv ----
// Self-checking bench for the velocity mode selector
`timescale 1ns/1ps
module vms_velocity_mode_select_test;
  localparam int STST = 400;
  typedef struct {
    logic [15:0] gap;
    logic [3:0] mres;
    logic ext;
    vms_pkg::vms_mode_t mode;
  } vms_row_t;
  // Thresholds: high speed 64, quiet chop 160, load adapt 320
  vms_row_t rows [4] = '{'{16'h015E, 4'h0, 1'h0, 3'h1},
    '{16'h00C8, 4'h0, 1'h1, 3'h5}, '{16'h0118, 4'h1, 1'h0, 3'h4},
    '{16'h00F0, 4'h2, 1'h1, 3'h2}};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] gap = 16'h0000;
  logic ext = 1'b0;
  logic step_int, step_ext_pin, standstill;
  vms_pkg::vms_mode_t mode;
  logic [4:0] current_scale;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  int miscompares = 0;
  int samples_checked = 0;
  initial forever #20 aclk = ~aclk;
  vms_step_source i_vms_step_source (.aclk, .gap, .ext, .step_int,
    .step_ext_pin);
  vms_velocity_mode_select #(.STST_CYCLES(STST)) i_vms_velocity_mode_select (
    .aclk, .aresetn, .step_int, .step_ext_pin, .mode, .standstill,
    .current_scale, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  task automatic end_sim;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge aclk);
  endtask : cyc
  // Outputs are sampled at the falling edge, one half period before use
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    logic aw_t, w_t, ar_t, rv_t, done;
    int n;
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    while (!done && n < 50) begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      ar_t = s_axi_arvalid && s_axi_arready;
      rv_t = s_axi_rvalid;
      // Read data waits one cycle for rready, so the hold is exercised
      done = w ? s_axi_bvalid : rv_t && s_axi_rready;
      rsp = w ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      if (ar_t) s_axi_arvalid <= 1'b0;
      if (done) s_axi_bready <= 1'b0;
      if (done) s_axi_rready <= 1'b0;
      else if (!w && rv_t) s_axi_rready <= 1'b1;
      n++;
    end
    if (!done) begin
      miscompares++;
      $display("mismatch at %0t: bus answer missing", $time);
    end
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000, 4'h0);
    chk(rd, e);
  endtask : rdc
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    $display("mismatch at %0t: run timed out", $time);
    end_sim();
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(1);
    chk(standstill, 1'b0);
    chk(current_scale, 5'h08);
    bus(1'b1, 8'h14, 32'h00000000, 4'hF);
    chk(rsp, 2'h2);
    rdc(8'h14, 32'h000FFFFF);
    rdc(8'h1C, 32'h00000000);
    chk(rsp, 2'h2);
    bus(1'b1, 8'h04, 32'h0000051A, 4'h1);
    chk(rsp, 2'h0);
    rdc(8'h04, 32'h0000081A);
    bus(1'b1, 8'h08, 32'h000000A0, 4'hF);
    bus(1'b1, 8'h0C, 32'h00000040, 4'hF);
    bus(1'b1, 8'h10, 32'h00000140, 4'hF);
    foreach (rows[i]) begin
      bus(1'b1, 8'h00, {24'h0, rows[i].mres, 2'h0, rows[i].ext, 1'h0},
          4'hF);
      gap <= rows[i].gap;
      ext <= rows[i].ext;
      cyc(3 * rows[i].gap + 20);
      chk(mode, rows[i].mode);
      chk(current_scale, 5'h1A);
      rdc(8'h14, {16'h0, rows[i].gap >> rows[i].mres});
    end
    // Interval exactly at the threshold keeps the fast state
    gap <= 16'h0100;
    cyc(800);
    chk(mode, 3'h2);
    gap <= 16'h0104;
    cyc(800);
    chk(mode, 3'h4);
    bus(1'b1, 8'h00, 32'h00000023, 4'hF);
    gap <= 16'h00F8;
    cyc(800);
    chk(mode, 3'h2);
    gap <= 16'h0000;
    cyc(STST + 20);
    chk(standstill, 1'b1);
    chk(current_scale, 5'h08);
    rdc(8'h18, 32'h00000003);
    rdc(8'h14, 32'h000FFFFF);
    gap <= 16'h0064;
    cyc(120);
    chk(standstill, 1'b0);
    chk(current_scale, 5'h1A);
    // Reset in mid-run while stepping must restore the outputs and the config, current and quiet chop registers
    @(posedge aclk);
    aresetn <= 1'b0;
    gap <= 16'h0000;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(1);
    chk(mode, 3'h0);
    chk(standstill, 1'b0);
    chk(current_scale, 5'h08);
    rdc(8'h00, 32'h00000000);
    rdc(8'h04, 32'h00000810);
    rdc(8'h08, 32'h00000000);
    end_sim();
  end
endmodule : vms_velocity_mode_select_test
